// File: dac_link_cfg.svh
// Constants for the twelve-channel serial level loader.
// Behaviour
// - Word is 4 address then 8 level bits
// - Top nibble addresses, low byte is level
// - Channel number equals address plus one
// - Clock edges ignored while select high
// - Rising clock with select low shifts data
// - Host holds clock high when select rises
// - Only last twelve shifted bits are kept
// - Select rise strobes one channel register, none if address is 12 or above or while preset is held
// - Chosen register takes the low eight bits
// - One word per channel, any order
// - Serial clock accepted only while each phase outlasts the 100 ns local clock the device samples it on
// - Preset loads every channel with 128
// - Preset acts without waiting for clocks
// - Shutdown keeps every stored level
// - Release of shutdown restores outputs
// - Shutdown open-circuits all twelve outputs
// - Each channel holds an 8-bit code
`ifndef DAC_LINK_CFG_SVH
`define DAC_LINK_CFG_SVH
`define WORD_BITS      12
`define ADDR_MSB       11
`define ADDR_LSB       8
`define LEVEL_MSB      7
`define CHANNELS       12
`define MIDSCALE       8'h80
`define LINK_MIN_NS    30
`define CLK_NS         100
`define HALF_PERIOD    4
`define HALF_CYCLES    ((`LINK_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: dac_link_if.sv
// Three-wire serial link plus preset and shutdown between host and device.
`timescale 1ns/100ps
interface dac_link_if;
  logic serialClk;
  logic selectN;
  logic serialInLine;
  logic midscalePresetN;
  logic powerDownN;
  modport host (output serialClk, output selectN, output serialInLine,
                output midscalePresetN, output powerDownN);
  modport device (input serialClk, input selectN, input serialInLine,
                  input midscalePresetN, input powerDownN);
endinterface

// File: dac_link_monitor.sv
// Checker of the host-driven signals of the serial level link.
`timescale 1ns/100ps
module dac_link_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic selectN,
  input wire logic serialInLine,
  input wire logic midscalePresetN,
  input wire logic powerDownN
);
  logic       lastClk;
  logic [4:0] rises;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lastClk <= 1'b1;
    else lastClk <= serialClk;
  end
  // Counting only inside a frame keeps stray idle edges out of the total.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rises <= 5'h00;
    else if (selectN) rises <= 5'h00;
    else if (serialClk && !lastClk) rises <= rises + 5'h01;
  end
  sequence lowHalf; !serialClk [*5] ##1 serialClk; endsequence
  sequence firstFall; serialClk ##[1:10] !serialClk; endsequence
  chk_close_clk_high: assert property ($rose(selectN) |-> serialClk)
    else $error("select rose with link clock low");
  chk_frame_twelve: assert property ($rose(selectN) |-> rises == 5'h0c)
    else $error("frame did not hold twelve clock rises");
  chk_idle_clk_still: assert property (selectN |-> $stable(serialClk))
    else $error("link clock moved outside a frame");
  chk_low_half: assert property ($fell(serialClk) |-> lowHalf)
    else $error("link clock low phase has wrong length");
  chk_high_half: assert property ($rose(serialClk) |-> serialClk [*5])
    else $error("link clock high phase too short");
  chk_data_steady: assert property (!serialClk && !$fell(serialClk)
    |-> $stable(serialInLine))
    else $error("data changed while link clock low");
  chk_select_gap: assert property ($rose(selectN) |-> selectN [*5])
    else $error("frames closer than the gap");
  chk_frame_open: assert property ($fell(selectN) |-> firstFall)
    else $error("frame opened without a clock cycle");
endmodule

// File: dac_link_pkg.sv
// Types shared by both ends of the serial level link.
package dac_link_pkg;
  typedef logic [7:0]  level_t;
  typedef logic [3:0]  chan_addr_t;
  typedef logic [11:0] word_t;
  typedef enum logic [3:0] {
    IDLE  = 4'b0001,
    SHIFT = 4'b0010,
    CLOSE = 4'b0100,
    GAP   = 4'b1000
  } host_state_t;
endpackage

// File: dac_loader_device.sv
// Device end: serial capture, address decode and twelve channel registers.
`timescale 1ns/100ps
`include "dac_link_cfg.svh"
module dac_loader_device (
  input  wire logic                 clk,
  input  wire logic                 rst,
  dac_link_if.device                link,
  output logic [`CHANNELS*8-1:0]    channelOutputs,
  output logic [`CHANNELS-1:0]      channelOutputEnable,
  output logic                      loadStrobe
);
  import dac_link_pkg::*;

  // Every link pin passes two flops before any logic sees it.
  logic [1:0] clkSync;
  logic [1:0] selSync;
  logic [1:0] dinSync;
  logic [1:0] presetSync;
  logic [1:0] downSync;
  logic       clkPrev;
  logic       selPrev;
  word_t      shiftReg;
  level_t     channelLevelRegister [`CHANNELS];

  function automatic logic validAddr(input chan_addr_t a);
    validAddr = (a < 4'(`CHANNELS));
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkSync    <= 2'b11;
      selSync    <= 2'b11;
      dinSync    <= 2'b00;
      presetSync <= 2'b11;
      downSync   <= 2'b11;
      clkPrev    <= 1'b1;
      selPrev    <= 1'b1;
    end else begin
      clkSync    <= {clkSync[0], link.serialClk};
      selSync    <= {selSync[0], link.selectN};
      dinSync    <= {dinSync[0], link.serialInLine};
      presetSync <= {presetSync[0], link.midscalePresetN};
      downSync   <= {downSync[0], link.powerDownN};
      clkPrev    <= clkSync[1];
      selPrev    <= selSync[1];
    end
  end

  logic clkRise;
  logic selRise;
  assign clkRise = clkSync[1] & ~clkPrev;
  assign selRise = selSync[1] & ~selPrev;

  // Older bits fall off the top, so only the last twelve remain.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftReg <= 12'h000;
    end else if (clkRise && !selSync[1]) begin
      shiftReg <= {shiftReg[`WORD_BITS-2:0], dinSync[1]};
    end
  end

  chan_addr_t addrField;
  assign addrField = shiftReg[`ADDR_MSB:`ADDR_LSB];

  // Preset is sampled through the synchroniser, so it needs no clock edge
  // on the link; the local clock is the only one that runs here.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `CHANNELS; i++) begin
        channelLevelRegister[i] <= `MIDSCALE;
      end
      loadStrobe <= 1'b0;
    end else if (!presetSync[1]) begin
      for (int i = 0; i < `CHANNELS; i++) begin
        channelLevelRegister[i] <= `MIDSCALE;
      end
      loadStrobe <= 1'b0;
    end else begin
      loadStrobe <= selRise && validAddr(addrField);
      // Address n drives channel n+1, held at array index n.
      if (selRise && validAddr(addrField)) begin
        channelLevelRegister[addrField] <=
          shiftReg[`LEVEL_MSB:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channelOutputs      <= '0;
      channelOutputEnable <= '0;
    end else begin
      for (int i = 0; i < `CHANNELS; i++) begin
        channelOutputs[i*8 +: 8] <= channelLevelRegister[i];
      end
      channelOutputEnable <= downSync[1] ? '1 : '0;
    end
  end
endmodule

// File: dac_loader_host.sv
// Host end: two-entry word buffer feeding a divided serial clock shifter.
`timescale 1ns/100ps
`include "dac_link_cfg.svh"
module dac_loader_host (
  input  wire logic                 clk,
  input  wire logic                 rst,
  dac_link_if.host                  link,
  input  wire logic                 wordValid,
  output logic                      wordReady,
  input  wire dac_link_pkg::word_t  wordData,
  input  wire logic                 presetRequest,
  input  wire logic                 shutdownRequest,
  output logic                      busy
);
  import dac_link_pkg::*;

  word_t       buffer [2];
  logic        wrPtr;
  logic        rdPtr;
  logic [1:0]  count;
  host_state_t state;
  word_t       shiftOut;
  logic [3:0]  bitsLeft;
  logic [2:0]  halfCount;
  logic        takeWord;

  assign wordReady = (count != 2'd2);
  assign takeWord  = (state == IDLE) && (count != 2'd0);
  assign busy      = (state != IDLE) || (count != 2'd0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr     <= 1'b0;
      rdPtr     <= 1'b0;
      count     <= 2'd0;
      buffer[0] <= 12'h000;
      buffer[1] <= 12'h000;
    end else begin
      if (wordValid && wordReady) begin
        buffer[wrPtr] <= wordData;
        wrPtr <= ~wrPtr;
      end
      if (takeWord) begin
        rdPtr <= ~rdPtr;
      end
      count <= count + 2'(wordValid && wordReady) - 2'(takeWord);
    end
  end

  // The link clock is a divided local clock; half period is far above
  // the 30 ns floor, so the device sampler always sees each level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state             <= IDLE;
      shiftOut          <= 12'h000;
      bitsLeft          <= 4'd0;
      halfCount         <= 3'd0;
      link.serialClk    <= 1'b1;
      link.selectN      <= 1'b1;
      link.serialInLine <= 1'b0;
    end else begin
      case (state)
        IDLE: begin
          link.serialClk <= 1'b1;
          link.selectN   <= 1'b1;
          if (takeWord) begin
            shiftOut          <= buffer[rdPtr];
            link.serialInLine <= buffer[rdPtr][`ADDR_MSB];
            bitsLeft          <= 4'(`WORD_BITS);
            halfCount         <= 3'(`HALF_PERIOD);
            link.selectN      <= 1'b0;
            state             <= SHIFT;
          end
        end
        SHIFT: begin
          if (halfCount != 3'd0) begin
            halfCount <= halfCount - 3'd1;
          end else begin
            halfCount <= 3'(`HALF_PERIOD);
            if (link.serialClk) begin
              link.serialClk    <= 1'b0;
              // Data moves on the falling edge, so the device's sampler
              // never sees it change together with the rising edge.
              link.serialInLine <= shiftOut[`WORD_BITS-1];
            end else begin
              link.serialClk <= 1'b1;
              shiftOut <= {shiftOut[`WORD_BITS-2:0], 1'b0};
              bitsLeft <= bitsLeft - 4'd1;
              if (bitsLeft == 4'd1) begin
                state <= CLOSE;
              end
            end
          end
        end
        CLOSE: begin
          if (halfCount != 3'd0) begin
            halfCount <= halfCount - 3'd1;
          end else begin
            link.selectN <= 1'b1;
            halfCount    <= 3'(`HALF_PERIOD);
            state        <= GAP;
          end
        end
        GAP: begin
          // Each word gets its own select frame.
          if (halfCount != 3'd0) begin
            halfCount <= halfCount - 3'd1;
          end else begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.midscalePresetN <= 1'b0;
      link.powerDownN      <= 1'b1;
    end else begin
      link.midscalePresetN <= ~presetRequest;
      link.powerDownN      <= ~shutdownRequest;
    end
  end
endmodule

// File: test_twelve_channel_dac_serial_loader.sv
// Bench joining the host and device ends of the level link.
`timescale 1ns/100ps
`define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  fails++; $display("unexpected at %0t: value mismatch", $time); end end
module test_twelve_channel_dac_serial_loader;
  import dac_link_pkg::*;
  typedef struct { word_t w; int idx; level_t lvl; } row_t;
  logic        clk, rst, wordValid, wordReady, busy, loadStrobe;
  logic        presetRequest, shutdownRequest;
  word_t       wordData;
  logic [95:0] chanOut, expOut;
  logic [11:0] chanEn;
  int          fails, comparisons, got, strobes;
  row_t        rows[4] = '{'{12'h03c, 0, 8'h3c}, '{12'hba5, 11, 8'ha5},
                           '{12'h5ff, 5, 8'hff}, '{12'h900, 9, 8'h00}};
  dac_link_if link();
  dac_loader_host u_dac_loader_host (.clk(clk), .rst(rst), .link(link),
    .wordValid(wordValid), .wordReady(wordReady), .wordData(wordData),
    .presetRequest(presetRequest), .shutdownRequest(shutdownRequest),
    .busy(busy));
  dac_loader_device u_dac_loader_device (.clk(clk), .rst(rst), .link(link),
    .channelOutputs(chanOut), .channelOutputEnable(chanEn),
    .loadStrobe(loadStrobe));
  dac_link_monitor mon (.clk(clk), .rst(rst), .serialClk(link.serialClk),
    .selectN(link.selectN), .serialInLine(link.serialInLine),
    .midscalePresetN(link.midscalePresetN), .powerDownN(link.powerDownN));
  always #50 clk = ~clk;
  always @(negedge clk) if (loadStrobe === 1'b1) strobes++;
  task automatic push(input word_t w);
    logic ok;
    wordValid = 1'b1;
    wordData = w;
    do begin ok = wordReady; @(negedge clk); end while (ok !== 1'b1);
  endtask
  task automatic waitLoad(output int hit);
    hit = 0;
    for (int i = 0; i < 400 && hit == 0; i++) begin
      @(negedge clk);
      hit = (loadStrobe === 1'b1);
    end
    // Channel outputs follow one edge after the strobe.
    @(negedge clk);
  endtask
  task automatic end_of_test();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1_000_000;
    fails++;
    end_of_test();
  end
  initial begin
    clk = 0; rst = 1; wordValid = 0; wordData = '0;
    presetRequest = 0; shutdownRequest = 0; expOut = {12{8'h80}};
    repeat (10) @(negedge clk);
    rst = 0;
    repeat (5) @(negedge clk);
    `CHECK(chanOut, expOut)
    `CHECK(chanEn, 12'hfff)
    foreach (rows[i]) begin
      push(rows[i].w);
      wordValid = 0;
      waitLoad(got);
      expOut[rows[i].idx*8 +: 8] = rows[i].lvl;
      `CHECK(got, 1)
      `CHECK(chanOut, expOut)
    end
    // An out-of-range word comes ahead of two good ones, all back to back.
    push(12'hc55); push(12'hb01); push(12'h0fe);
    `CHECK(wordReady, 1'b0)
    `CHECK(busy, 1'b1)
    wordValid = 0;
    waitLoad(got);
    expOut[88 +: 8] = 8'h01;
    `CHECK(chanOut, expOut)
    `CHECK(strobes, 5)
    waitLoad(got);
    expOut[0 +: 8] = 8'hfe;
    `CHECK(chanOut, expOut)
    shutdownRequest = 1;
    repeat (10) @(negedge clk);
    `CHECK(chanEn, 12'h000)
    `CHECK(busy, 1'b0)
    `CHECK(chanOut, expOut)
    shutdownRequest = 0;
    repeat (10) @(negedge clk);
    `CHECK(chanEn, 12'hfff)
    `CHECK(chanOut, expOut)
    // Preset lands in mid-frame, so it must not wait for the link clock.
    push(12'h1aa);
    wordValid = 0;
    repeat (30) @(negedge clk);
    presetRequest = 1;
    waitLoad(got);
    expOut = {12{8'h80}};
    `CHECK(got, 0)
    `CHECK(strobes, 6)
    `CHECK(chanOut, expOut)
    presetRequest = 0;
    end_of_test();
  end
endmodule
